//--- include/lib_pkg.sv
// shared constants for the lpc to isa bridge and its lpc host end
// assumes one 10 MHz clock for both ends and a synchronous active-low reset
package lib_pkg;

	// clock and derived timing
	localparam int          CLK_PERIOD_NS     = 100;
	localparam int          REFRESH_PERIOD_NS = 15000;
	localparam int          REFRESH_CYCLES    = REFRESH_PERIOD_NS / CLK_PERIOD_NS;

	// lpc nibble codes
	localparam logic [3:0]  LAD_START   = 4'h0;
	localparam logic [3:0]  LAD_ABORT   = 4'hF;
	localparam logic [3:0]  LAD_IDLE    = 4'hF;
	localparam logic [3:0]  SYNC_READY  = 4'h0;
	localparam logic [3:0]  SYNC_LWAIT  = 4'h6;
	localparam logic [1:0]  CYC_IO      = 2'h0;
	localparam logic [1:0]  CYC_MEM     = 2'h1;
	localparam logic [2:0]  IO_LAST_NIB  = 3'h3;
	localparam logic [2:0]  MEM_LAST_NIB = 3'h7;
	localparam logic [2:0]  TAR_LAST     = 3'h1;
	localparam logic [2:0]  DATA_LAST    = 3'h1;
	localparam logic [2:0]  ABORT_LAST   = 3'h3;

	// isa clock divider: counter tops for divide by 3 or 4
	localparam logic [1:0]  DIV3_TOP    = 2'h2;
	localparam logic [1:0]  DIV4_TOP    = 2'h3;
	localparam logic [1:0]  DIV_FALL    = 2'h1;

	// isa command lengths in isa clocks
	localparam logic [2:0]  CMD_TICKS_8  = 3'h4;
	localparam logic [2:0]  CMD_TICKS_16 = 3'h2;
	localparam logic [3:0]  MEG_PAGE     = 4'h0;

	// encoded dma request frame and channel mask (channel 4 is cascade)
	localparam logic [2:0]  LDRQ_BITS   = 3'h5;
	localparam logic [7:0]  DRQ_MASK    = 8'hEF;

	// serial interrupt frame
	localparam logic [7:0]  SIRQ_START_CLKS = 8'h04;
	localparam logic [3:0]  SIRQ_LAST_SLOT  = 4'hF;
	localparam logic [1:0]  SIRQ_LAST_PH    = 2'h2;
	localparam logic [7:0]  SIRQ_FRAME_CLKS = 8'h35;
	localparam logic [7:0]  SIRQ_PERIOD     = 8'h80;

endpackage

//--- include/lib_lpc_if.sv
// lpc link between the host end and the bridge end
// resolves the shared lad nibble and the open-drain serial interrupt wire
`timescale 1ns/1ns
interface lib_lpc_if import lib_pkg::*; ();
	logic [3:0] lad_h_o;
	logic       lad_h_oe;
	logic [3:0] lad_d_o;
	logic       lad_d_oe;
	logic [3:0] lad;
	logic       lframe_n;
	logic       ldrq_n;
	logic       serirq_h_oe;
	logic       serirq_d_oe;
	logic       serirq;

	// pulled-up lad, host wins a clash; serirq is wired-and
	assign lad    = lad_h_oe ? lad_h_o : (lad_d_oe ? lad_d_o : LAD_IDLE);
	assign serirq = ~(serirq_h_oe | serirq_d_oe);

	modport device (input lad, lframe_n, serirq, output lad_d_o, lad_d_oe, ldrq_n, serirq_d_oe);
	modport host   (input lad, ldrq_n, serirq, output lad_h_o, lad_h_oe, lframe_n, serirq_h_oe);
endinterface

//--- verilog/lib_host.sv
// lpc host end: runs io and memory cycles, decodes dma and serial irq
// assumes the bridge end on the same clock through lib_lpc_if
`timescale 1ns/1ns
module lib_host import lib_pkg::*; (
	input  wire logic        sys_clk_in,     // lpc clock
	input  wire logic        rst_n_in,       // sync reset
	lib_lpc_if.host          lpc,            // lpc link
	input  wire logic        cmd_valid_in,   // request
	output logic             cmd_ready_out,  // idle, request taken
	input  wire logic        cmd_io_in,      // 1 io, 0 memory
	input  wire logic        cmd_write_in,   // 1 write
	input  wire logic [31:0] cmd_addr_in,    // address
	input  wire logic [7:0]  cmd_wdata_in,   // write byte
	input  wire logic        abort_in,       // abort current cycle
	output logic             done_out,       // cycle finished pulse
	output logic [7:0]       rdata_out,      // read byte
	output logic [15:0]      irq_level_out,  // irq levels from serial frame
	output logic [7:0]       dma_req_out     // dma request levels
);
	typedef enum logic [3:0] {H_IDLE, H_START, H_TYPE, H_ADDR, H_WDATA, H_TAR, H_SYNC,
		H_RDATA, H_TAR2, H_ABORT} lib_hstate_e;

	lib_hstate_e st_r;
	logic [2:0]  nib_r;
	logic        io_r;
	logic        wr_r;
	logic [31:0] addr_r;
	logic [7:0]  wd_r;
	logic [2:0]  last_w;
	logic [7:0]  sq_cnt_r;
	logic [7:0]  sq_off_w;
	logic [2:0]  lq_cnt_r;
	logic [3:0]  lq_sh_r;

	assign last_w        = io_r ? IO_LAST_NIB : MEM_LAST_NIB;
	assign cmd_ready_out = (st_r == H_IDLE);

	// cycle sequencer; abort restarts the device decoder
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_r  <= H_IDLE;
			nib_r <= 3'h0;
			io_r  <= 1'b0;
			wr_r  <= 1'b0;
			addr_r <= 32'h0000_0000;
			wd_r  <= 8'h00;
			done_out  <= 1'b0;
			rdata_out <= 8'h00;
		end else begin
			done_out <= 1'b0;
			nib_r <= nib_r + 3'h1;
			if (abort_in && st_r != H_IDLE && st_r != H_ABORT) begin
				st_r  <= H_ABORT;
				nib_r <= 3'h0;
			end else begin
				unique case (st_r)
					H_IDLE: begin
						nib_r <= 3'h0;
						if (cmd_valid_in) begin
							st_r   <= H_START;
							io_r   <= cmd_io_in;
							wr_r   <= cmd_write_in;
							addr_r <= cmd_addr_in;
							wd_r   <= cmd_wdata_in;
						end
					end
					H_START: begin
						st_r  <= H_TYPE;
						nib_r <= 3'h0;
					end
					H_TYPE: begin
						st_r  <= H_ADDR;
						nib_r <= 3'h0;
					end
					H_ADDR: if (nib_r == last_w) begin
						st_r  <= wr_r ? H_WDATA : H_TAR;
						nib_r <= 3'h0;
					end
					H_WDATA: if (nib_r == DATA_LAST) begin
						st_r  <= H_TAR;
						nib_r <= 3'h0;
					end
					H_TAR: if (nib_r == TAR_LAST) st_r <= H_SYNC;
					H_SYNC: begin
						nib_r <= 3'h0;
						if (lpc.lad == SYNC_READY) st_r <= wr_r ? H_TAR2 : H_RDATA;
					end
					H_RDATA: begin
						if (nib_r == 3'h0) rdata_out[3:0] <= lpc.lad;
						else rdata_out[7:4] <= lpc.lad;
						if (nib_r == DATA_LAST) begin
							st_r  <= H_TAR2;
							nib_r <= 3'h0;
						end
					end
					H_TAR2: if (nib_r == TAR_LAST) begin
						st_r     <= H_IDLE;
						done_out <= 1'b1;
					end
					H_ABORT: if (nib_r == ABORT_LAST) st_r <= H_IDLE;
				endcase
			end
		end
	end

	// lad and frame drive decode
	always_comb begin
		lpc.lad_h_o  = LAD_IDLE;
		lpc.lad_h_oe = 1'b1;
		lpc.lframe_n = 1'b1;
		unique case (st_r)
			H_START: begin
				lpc.lad_h_o  = LAD_START;
				lpc.lframe_n = 1'b0;
			end
			H_TYPE:  lpc.lad_h_o = {io_r ? CYC_IO : CYC_MEM, wr_r, 1'b0};
			H_ADDR:  lpc.lad_h_o = 4'((addr_r >> {last_w - nib_r, 2'h0}));
			H_WDATA: lpc.lad_h_o = (nib_r == 3'h0) ? wd_r[3:0] : wd_r[7:4];
			H_TAR:   lpc.lad_h_oe = (nib_r == 3'h0);
			H_ABORT: begin
				lpc.lad_h_o  = LAD_ABORT;
				lpc.lframe_n = 1'b0;
			end
			default: lpc.lad_h_oe = (st_r == H_IDLE);
		endcase
	end

	// serial irq frame: start pulse, release, then 16 three-clock slots
	assign sq_off_w        = sq_cnt_r - SIRQ_START_CLKS - 8'h01;
	assign lpc.serirq_h_oe = (sq_cnt_r < SIRQ_START_CLKS);
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			sq_cnt_r      <= 8'h00;
			irq_level_out <= 16'h0000;
		end else begin
			sq_cnt_r <= (sq_cnt_r == SIRQ_PERIOD - 8'h01) ? 8'h00 : sq_cnt_r + 8'h01;
			if (sq_cnt_r > SIRQ_START_CLKS && sq_cnt_r < SIRQ_FRAME_CLKS
				&& (sq_off_w % 8'h03) == 8'h00)
				irq_level_out[4'(sq_off_w / 8'h03)] <= ~lpc.serirq;
		end
	end

	// encoded dma request decode: start, channel msb first, level
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			lq_cnt_r    <= 3'h0;
			lq_sh_r     <= 4'h0;
			dma_req_out <= 8'h00;
		end else if (lq_cnt_r == 3'h0) begin
			if (!lpc.ldrq_n) lq_cnt_r <= 3'h1;
		end else begin
			lq_sh_r  <= {lq_sh_r[2:0], lpc.ldrq_n};
			lq_cnt_r <= (lq_cnt_r == LDRQ_BITS - 3'h1) ? 3'h0 : lq_cnt_r + 3'h1;
			if (lq_cnt_r == LDRQ_BITS - 3'h1)
				dma_req_out[lq_sh_r[2:0]] <= lpc.ldrq_n;
		end
	end
endmodule

//--- verilog/lib_bridge.sv
// lpc to isa bridge end: decodes lpc cycles and runs matching isa cycles
// assumes the lpc host on the same clock; isa pins split into out/enable/in
`timescale 1ns/1ns
module lib_bridge import lib_pkg::*; #(
	parameter int REFRESH_CYCLES_P = REFRESH_CYCLES  // clocks between refreshes
) (
	input  wire logic        sys_clk_in,      // lpc clock
	input  wire logic        rst_n_in,        // sync reset
	lib_lpc_if.device        lpc,             // lpc link
	input  wire logic        div4_sel_in,     // 1 divide by 4, 0 by 3
	output logic             sysclk_out,      // isa clock
	output logic             rstdrv_out,      // isa reset
	output logic [19:0]      sa_out,          // system address
	output logic             sa_oe_out,       // system address enable
	output logic [6:0]       la_out,          // unlatched address 23:17
	output logic             la_oe_out,       // unlatched address enable
	output logic             sbhe_n_out,      // byte high enable
	output logic             bale_out,        // address latch enable
	output logic             aen_out,         // address enable
	output logic             ior_n_out,       // io read
	output logic             iow_n_out,       // io write
	output logic             memr_n_out,      // memory read
	output logic             memw_n_out,      // memory write
	output logic             cmd_oe_out,      // strobe enable
	output logic             smemr_n_out,     // standard memory read
	output logic             smemw_n_out,     // standard memory write
	output logic             refresh_n_out,   // refresh
	output logic             refresh_oe_out,  // refresh enable
	input  wire logic [15:0] sd_in,           // data in
	output logic [15:0]      sd_out,          // data out
	output logic             sd_oe_out,       // data enable
	input  wire logic        iochrdy_in,      // channel ready
	input  wire logic        iocs16_n_in,     // io 16-bit select
	input  wire logic        memcs16_n_in,    // memory 16-bit select
	input  wire logic        zws_n_in,        // zero wait states
	input  wire logic        iochck_n_in,     // channel check
	output logic             chan_check_out,  // bus error level
	input  wire logic [15:0] irq_in,          // parallel irq lines
	input  wire logic [7:0]  drq_in           // dma request lines
);
	typedef enum logic [2:0] {L_IDLE, L_TYPE, L_ADDR, L_WDATA, L_TARH, L_SYNC, L_RDATA,
		L_TARD} lib_lstate_e;
	typedef enum logic [2:0] {I_IDLE, I_ADDR, I_CMD, I_END, I_RADDR, I_RCMD} lib_istate_e;

	// lowest channel whose request level changed
	function automatic logic [2:0] lib_first(input logic [7:0] v);
		logic [2:0] k;
		k = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (v[i]) k = 3'(i);
		return k;
	endfunction

	lib_lstate_e lst_r;
	lib_istate_e ist_r;
	logic [2:0]  nib_r;
	logic        io_r;
	logic        wr_r;
	logic [23:0] addr_r;
	logic [7:0]  wd_r;
	logic        pend_r;
	logic        done_r;
	logic [7:0]  rd_r;
	logic [1:0]  div_r;
	logic        tick_w;
	logic        accept_w;
	logic        iend_w;
	logic [23:0] iaddr_r;
	logic        iio_r;
	logic        iwr_r;
	logic        wide_r;
	logic        ref_r;
	logic [2:0]  cnt_r;
	logic        zws_ok_w;
	logic [15:0] rcnt_r;
	logic        rdue_r;
	logic [7:0]  row_r;
	logic        cmd_w;
	logic        low1m_w;
	logic [7:0]  lq_sent_r;
	logic [7:0]  lq_diff_w;
	logic [4:0]  lq_sh_r;
	logic [2:0]  lq_cnt_r;
	logic        sq_start_r;
	logic        sq_act_r;
	logic [3:0]  slot_r;
	logic [1:0]  ph_r;

	// lpc decoder; frame low always restarts it
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			lst_r  <= L_IDLE;
			nib_r  <= 3'h0;
			io_r   <= 1'b0;
			wr_r   <= 1'b0;
			addr_r <= 24'h00_0000;
			wd_r   <= 8'h00;
		end else if (!lpc.lframe_n) begin
			lst_r <= (lpc.lad == LAD_START) ? L_TYPE : L_IDLE;
			nib_r <= 3'h0;
		end else begin
			nib_r <= nib_r + 3'h1;
			unique case (lst_r)
				L_IDLE: nib_r <= 3'h0;
				L_TYPE: begin
					addr_r <= 24'h00_0000; // io cycles leave the upper bits clear
					io_r  <= (lpc.lad[3:2] == CYC_IO);
					wr_r  <= lpc.lad[1];
					nib_r <= 3'h0;
					lst_r <= (lpc.lad[3:2] == CYC_IO || lpc.lad[3:2] == CYC_MEM) ? L_ADDR : L_IDLE;
				end
				L_ADDR: begin
					addr_r <= {addr_r[19:0], lpc.lad};
					if (nib_r == (io_r ? IO_LAST_NIB : MEM_LAST_NIB)) begin
						lst_r <= wr_r ? L_WDATA : L_TARH;
						nib_r <= 3'h0;
					end
				end
				L_WDATA: begin
					if (nib_r == 3'h0) wd_r[3:0] <= lpc.lad;
					else wd_r[7:4] <= lpc.lad;
					if (nib_r == DATA_LAST) begin
						lst_r <= L_TARH;
						nib_r <= 3'h0;
					end
				end
				L_TARH: if (nib_r == TAR_LAST) lst_r <= L_SYNC;
				L_SYNC: begin
					nib_r <= 3'h0;
					if (done_r) lst_r <= wr_r ? L_TARD : L_RDATA;
				end
				L_RDATA: if (nib_r == DATA_LAST) begin
					lst_r <= L_TARD;
					nib_r <= 3'h0;
				end
				L_TARD: if (nib_r == TAR_LAST) lst_r <= L_IDLE;
			endcase
		end
	end

	// handoff to the isa side; a stale end from an aborted cycle is ignored
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pend_r <= 1'b0;
			done_r <= 1'b0;
		end else if (lpc.lframe_n && lst_r == L_TARH && nib_r == TAR_LAST) begin
			pend_r <= 1'b1;
			done_r <= 1'b0;
		end else begin
			if (accept_w) pend_r <= 1'b0;
			if (iend_w && !pend_r) done_r <= 1'b1;
		end
	end

	// lad drive: long wait until the isa cycle ends, then ready and data
	always_comb begin
		lpc.lad_d_oe = 1'b1;
		lpc.lad_d_o  = LAD_IDLE;
		unique case (lst_r)
			L_SYNC:  lpc.lad_d_o = done_r ? SYNC_READY : SYNC_LWAIT;
			L_RDATA: lpc.lad_d_o = (nib_r == 3'h0) ? rd_r[3:0] : rd_r[7:4];
			L_TARD:  lpc.lad_d_oe = (nib_r == 3'h0);
			default: lpc.lad_d_oe = 1'b0;
		endcase
		// host owns lad while frame is low, so an abort never meets our drive
		if (!lpc.lframe_n) lpc.lad_d_oe = 1'b0;
	end

	// isa clock divider, one tick per isa clock rise
	assign tick_w = (div_r == (div4_sel_in ? DIV4_TOP : DIV3_TOP));
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			div_r      <= 2'h0;
			sysclk_out <= 1'b0;
		end else begin
			div_r <= tick_w ? 2'h0 : div_r + 2'h1;
			if (tick_w) sysclk_out <= 1'b1;
			else if (div_r == DIV_FALL) sysclk_out <= 1'b0;
		end
	end

	// refresh timer; a due request survives its own clear
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			rcnt_r <= 16'h0000;
			rdue_r <= 1'b0;
		end else begin
			rcnt_r <= (rcnt_r == 16'(REFRESH_CYCLES_P - 1)) ? 16'h0000 : rcnt_r + 16'h0001;
			if (rcnt_r == 16'(REFRESH_CYCLES_P - 1)) rdue_r <= 1'b1;
			else if (tick_w && ist_r == I_IDLE && !pend_r) rdue_r <= 1'b0;
		end
	end

	// isa cycle engine, stepped only on isa clock ticks
	assign accept_w = tick_w && ist_r == I_IDLE && pend_r;
	assign iend_w   = tick_w && ist_r == I_END && !ref_r;
	assign zws_ok_w = !zws_n_in && !(iio_r && wide_r);
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			ist_r   <= I_IDLE;
			iaddr_r <= 24'h00_0000;
			iio_r   <= 1'b0;
			iwr_r   <= 1'b0;
			wide_r  <= 1'b0;
			ref_r   <= 1'b0;
			cnt_r   <= 3'h0;
			row_r   <= 8'h00;
			rd_r    <= 8'h00;
			sd_out  <= 16'h0000;
		end else if (tick_w) begin
			unique case (ist_r)
				I_IDLE: if (pend_r) begin
					ist_r   <= I_ADDR;
					iaddr_r <= addr_r;
					iio_r   <= io_r;
					iwr_r   <= wr_r;
					ref_r   <= 1'b0;
					sd_out  <= {wd_r, wd_r};
				end else if (rdue_r) begin
					ist_r <= I_RADDR;
					ref_r <= 1'b1;
				end
				I_ADDR: begin
					ist_r  <= I_CMD;
					wide_r <= iio_r ? !iocs16_n_in : !memcs16_n_in;
					cnt_r  <= (iio_r ? !iocs16_n_in : !memcs16_n_in) ? CMD_TICKS_16 : CMD_TICKS_8;
				end
				I_CMD: begin
					if (cnt_r > 3'h1) cnt_r <= cnt_r - 3'h1;
					if (zws_ok_w || (cnt_r <= 3'h1 && iochrdy_in)) begin
						ist_r <= I_END;
						rd_r  <= (iaddr_r[0] && wide_r) ? sd_in[15:8] : sd_in[7:0];
					end
				end
				I_RADDR: begin
					ist_r <= I_RCMD;
					cnt_r <= CMD_TICKS_8;
				end
				I_RCMD: begin
					if (cnt_r > 3'h1) cnt_r <= cnt_r - 3'h1;
					if (cnt_r <= 3'h1 && iochrdy_in) begin
						ist_r <= I_END;
						row_r <= row_r + 8'h01;
					end
				end
				I_END: ist_r <= I_IDLE;
			endcase
		end
	end

	// isa pin decode from engine state
	assign cmd_w          = (ist_r == I_CMD);
	assign low1m_w        = (iaddr_r[23:20] == MEG_PAGE);
	assign rstdrv_out     = !rst_n_in;
	assign sa_oe_out      = (ist_r != I_IDLE);
	assign sa_out         = ref_r ? {12'h000, row_r} : iaddr_r[19:0];
	assign la_oe_out      = (ist_r != I_IDLE) && !ref_r;
	assign la_out         = iaddr_r[23:17];
	assign sbhe_n_out     = !(iaddr_r[0] && !ref_r);
	assign bale_out       = (ist_r == I_ADDR) || (ist_r == I_RADDR) || (ist_r == I_RCMD);
	assign aen_out        = ref_r && (ist_r != I_IDLE);
	assign cmd_oe_out     = (ist_r != I_IDLE);
	assign ior_n_out      = !(cmd_w && iio_r && !iwr_r);
	assign iow_n_out      = !(cmd_w && iio_r && iwr_r);
	assign memr_n_out     = !((cmd_w && !iio_r && !iwr_r) || ist_r == I_RCMD);
	assign memw_n_out     = !(cmd_w && !iio_r && iwr_r);
	assign smemr_n_out    = !((cmd_w && !iio_r && !iwr_r && low1m_w) || ist_r == I_RCMD);
	assign smemw_n_out    = !(cmd_w && !iio_r && iwr_r && low1m_w);
	assign refresh_n_out  = !(ref_r && ist_r != I_IDLE);
	assign refresh_oe_out = rst_n_in;
	assign sd_oe_out      = rst_n_in && iwr_r && !ref_r && (cmd_w || ist_r == I_END);

	// channel check level passed on as bus error
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) chan_check_out <= 1'b0;
		else chan_check_out <= !iochck_n_in;
	end

	// encoded dma request sender: start bit, channel, level
	assign lq_diff_w  = (drq_in ^ lq_sent_r) & DRQ_MASK;
	assign lpc.ldrq_n = (lq_cnt_r == 3'h0) ? 1'b1 : lq_sh_r[4];
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			lq_sent_r <= 8'h00;
			lq_sh_r   <= 5'h1F;
			lq_cnt_r  <= 3'h0;
		end else if (lq_cnt_r != 3'h0) begin
			lq_sh_r  <= {lq_sh_r[3:0], 1'b1};
			lq_cnt_r <= (lq_cnt_r == LDRQ_BITS) ? 3'h0 : lq_cnt_r + 3'h1;
		end else if (lq_diff_w != 8'h00) begin
			lq_sh_r  <= {1'b0, lib_first(lq_diff_w), drq_in[lib_first(lq_diff_w)]};
			lq_cnt_r <= 3'h1;
			lq_sent_r[lib_first(lq_diff_w)] <= drq_in[lib_first(lq_diff_w)];
		end
	end

	// serial irq slots: follow host start pulse, pull low for a high irq
	assign lpc.serirq_d_oe = sq_act_r && ph_r == 2'h0 && irq_in[slot_r];
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			sq_start_r <= 1'b0;
			sq_act_r   <= 1'b0;
			slot_r     <= 4'h0;
			ph_r       <= 2'h0;
		end else if (!sq_act_r) begin
			if (!lpc.serirq) sq_start_r <= 1'b1;
			else if (sq_start_r) begin
				sq_start_r <= 1'b0;
				sq_act_r   <= 1'b1;
				slot_r     <= 4'h0;
				ph_r       <= 2'h0;
			end
		end else begin
			ph_r <= (ph_r == SIRQ_LAST_PH) ? 2'h0 : ph_r + 2'h1;
			if (ph_r == SIRQ_LAST_PH) begin
				slot_r <= slot_r + 4'h1;
				if (slot_r == SIRQ_LAST_SLOT) sq_act_r <= 1'b0;
			end
		end
	end
endmodule

//--- tb/lib_lpc_sva.sv
// lpc link checker: frame codes, abort, sync wait, dma and irq framing
// assumes one clock and a sync active-low reset shared with both ends
`timescale 1ns/1ns
module lib_lpc_sva import lib_pkg::*; (
	input wire logic       sys_clk_in,  // lpc clock
	input wire logic       rst_n_in,    // sync reset
	input wire logic [3:0] lad_h_o,     // host nibble
	input wire logic       lad_h_oe,    // host drive
	input wire logic [3:0] lad_d_o,     // bridge nibble
	input wire logic       lad_d_oe,    // bridge drive
	input wire logic [3:0] lad,         // resolved nibble
	input wire logic       lframe_n,    // frame
	input wire logic       ldrq_n,      // dma request line
	input wire logic       serirq_h_oe, // host pull low
	input wire logic       serirq_d_oe, // bridge pull low
	input wire logic       serirq       // serial irq wire
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	// link framing and turnaround relations
	a_lad_one_driver: assert property (!(lad_h_oe && lad_d_oe))
		else $error("lad driven by both ends");
	a_frame_start_code: assert property ($fell(lframe_n) |-> lad == LAD_START || lad == LAD_ABORT)
		else $error("frame fell with bad nibble");
	a_start_one_clock: assert property (!lframe_n && lad == LAD_START |=> lframe_n)
		else $error("frame held after start");
	a_abort_four_clks: assert property ($fell(lframe_n) && lad == LAD_ABORT |-> !lframe_n [*4])
		else $error("abort shorter than four clocks");
	a_bridge_off_frame: assert property (!lframe_n && !$past(lframe_n) |-> !lad_d_oe)
		else $error("bridge drives lad during frame");
	a_wait_bounded: assert property (lad_d_oe && lad_d_o == SYNC_LWAIT |->
		##[1:600] (lad_d_oe && lad_d_o == SYNC_READY) || !lframe_n)
		else $error("sync wait never ended");
	a_ldrq_frame_len: assert property ($fell(ldrq_n) |-> ##5 ldrq_n)
		else $error("dma request frame length wrong");
	a_serirq_start: assert property ($rose(serirq_h_oe) |-> serirq_h_oe [*4] ##1 !serirq_h_oe)
		else $error("serial irq start length wrong");
endmodule

//--- tb/testbench.sv
// bench: host end and bridge end joined by the lpc link, isa slave played here
// assumes the package constants and a 100 ns clock
`timescale 1ns/1ns
module testbench;
	import lib_pkg::*;
	typedef struct {
		logic io, wr, cs16, zws;
		logic [31:0] addr;
		logic [7:0] wd;
		logic [15:0] sd;
		logic [7:0] rd;
		int lo, hi;
	} lib_row_s;
	logic clk, rst_n, div4, cv, ready, cio, cw, abort, done;
	logic [31:0] caddr;
	logic [7:0] cwd, rdata, dmar, drq;
	logic [15:0] irql, irq, sd_in, sd_out;
	logic sclk, rstdrv, sbhe_n, bale, aen, ior_n, iow_n, memr_n, memw_n, smemr_n, smemw_n;
	logic ref_n, ref_oe, sd_oe, rdy, iocs16_n, memcs16_n, zws_n, chk_n, chan;
	logic la_oe, sa_oe, cmd_oe;
	logic [19:0] sa;
	logic [6:0] la;
	int n_mismatch, num_checks;
	// io, wr, cs16, zws, addr, wdata, slave data, read byte, strobe clocks
	lib_row_s rows [7] = '{
		'{1'h1, 1'h1, 1'h0, 1'h0, 32'h0000_0300, 8'hA5, 16'h0000, 8'h00, 12, 12},
		'{1'h1, 1'h0, 1'h0, 1'h0, 32'h0000_0301, 8'h00, 16'h5A3C, 8'h3C, 12, 12},
		'{1'h1, 1'h0, 1'h1, 1'h0, 32'h0000_0301, 8'h00, 16'h5A3C, 8'h5A, 6, 6},
		'{1'h1, 1'h0, 1'h1, 1'h1, 32'h0000_0302, 8'h00, 16'h5A3C, 8'h3C, 6, 6},
		'{1'h0, 1'h1, 1'h0, 1'h1, 32'h000C_8001, 8'h3C, 16'h0000, 8'h00, 3, 11},
		'{1'h0, 1'h0, 1'h1, 1'h0, 32'h00FE_0010, 8'h00, 16'h1234, 8'h34, 6, 6},
		'{1'h0, 1'h0, 1'h0, 1'h0, 32'h000F_0000, 8'h00, 16'h00C3, 8'hC3, 12, 12}};

	lib_lpc_if lpc_if ();
	lib_host lib_host_inst (.sys_clk_in(clk), .rst_n_in(rst_n), .lpc(lpc_if), .cmd_valid_in(cv),
		.cmd_ready_out(ready), .cmd_io_in(cio), .cmd_write_in(cw), .cmd_addr_in(caddr),
		.cmd_wdata_in(cwd), .abort_in(abort), .done_out(done), .rdata_out(rdata),
		.irq_level_out(irql), .dma_req_out(dmar));
	lib_bridge #(.REFRESH_CYCLES_P(200)) lib_bridge_inst (.sys_clk_in(clk), .rst_n_in(rst_n),
		.lpc(lpc_if), .div4_sel_in(div4), .sysclk_out(sclk), .rstdrv_out(rstdrv), .sa_out(sa),
		.sa_oe_out(sa_oe), .la_out(la), .la_oe_out(la_oe), .sbhe_n_out(sbhe_n), .bale_out(bale),
		.aen_out(aen), .ior_n_out(ior_n), .iow_n_out(iow_n), .memr_n_out(memr_n),
		.memw_n_out(memw_n), .cmd_oe_out(cmd_oe), .smemr_n_out(smemr_n), .smemw_n_out(smemw_n),
		.refresh_n_out(ref_n), .refresh_oe_out(ref_oe), .sd_in(sd_in), .sd_out(sd_out),
		.sd_oe_out(sd_oe), .iochrdy_in(rdy), .iocs16_n_in(iocs16_n), .memcs16_n_in(memcs16_n),
		.zws_n_in(zws_n), .iochck_n_in(chk_n), .chan_check_out(chan), .irq_in(irq), .drq_in(drq));
	lib_lpc_sva lib_lpc_sva_inst (.sys_clk_in(clk), .rst_n_in(rst_n), .lad_h_o(lpc_if.lad_h_o),
		.lad_h_oe(lpc_if.lad_h_oe), .lad_d_o(lpc_if.lad_d_o), .lad_d_oe(lpc_if.lad_d_oe),
		.lad(lpc_if.lad), .lframe_n(lpc_if.lframe_n), .ldrq_n(lpc_if.ldrq_n),
		.serirq_h_oe(lpc_if.serirq_h_oe), .serirq_d_oe(lpc_if.serirq_d_oe),
		.serirq(lpc_if.serirq));

	// clock generator
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic timeout;
		n_mismatch++;
		$display("Error at %0t: got %h expected %h", $time, 1'h0, 1'h1);
		final_report();
	endtask
	// reset held two clocks with isa side checks
	task automatic do_reset(input logic d4);
		rst_n = 1'h0;
		div4 = d4;
		repeat (2) @(negedge clk);
		chk_v(32'(rstdrv), 32'h1);
		chk_v(32'(sd_oe), 32'h0);
		chk_v(32'(aen), 32'h0);
		chk_v(32'(bale), 32'h0);
		chk_v(32'(ref_oe), 32'h0);
		chk_v(32'({sa_oe, la_oe, cmd_oe}), 32'h0);
		rst_n = 1'h1;
		@(negedge clk);
		chk_v(32'(rstdrv), 32'h0);
	endtask
	// isa clock period from two rising edges
	task automatic per_chk(input int exp);
		int a, b;
		logic p;
		a = 0;
		b = 0;
		p = sclk;
		for (int i = 0; i < 20; i++) begin
			@(negedge clk);
			if (sclk && !p) begin
				a = b;
				b = i;
			end
			p = sclk;
		end
		chk_v(32'(b - a), 32'(exp));
	endtask
	task automatic issue(input lib_row_s r);
		for (int i = 0; i < 500 && ready !== 1'h1; i++) @(negedge clk);
		if (ready !== 1'h1) timeout();
		cio = r.io;
		cw = r.wr;
		caddr = r.addr;
		cwd = r.wd;
		sd_in = r.sd;
		iocs16_n = !(r.cs16 && r.io);
		memcs16_n = !(r.cs16 && !r.io);
		zws_n = !r.zws;
		cv = 1'h1;
		@(negedge clk);
		cv = 1'h0;
	endtask
	function automatic logic strobe(input lib_row_s r);
		return r.io ? (r.wr ? iow_n : ior_n) : (r.wr ? memw_n : memr_n);
	endfunction
	// one lpc command with the matching isa cycle watched
	task automatic run(input lib_row_s r);
		int len;
		logic sm, sb;
		logic [19:0] sa_s;
		logic [7:0] la_s;
		logic [7:0] wd_s;
		len = 0;
		sm = 1'h0;
		issue(r);
		for (int i = 0; i < 3000 && done !== 1'h1; i++) begin
			@(negedge clk);
			if (aen === 1'h0 && strobe(r) === 1'h0) begin
				len++;
				sa_s = sa;
				la_s = {la_oe, la};
				sb = sbhe_n;
				wd_s = sd_out[7:0];
				if ((r.wr ? smemw_n : smemr_n) === 1'h0) sm = 1'h1;
			end
		end
		if (done !== 1'h1) timeout();
		chk_v(32'(sa_s), 32'(r.addr[19:0]));
		chk_v(32'(r.wr ? wd_s : rdata), 32'(r.wr ? r.wd : r.rd));
		chk_v(32'(sm), 32'(!r.io && r.addr < 32'h0010_0000));
		chk_v(32'(sb), 32'(!r.addr[0]));
		if (!r.io) chk_v(32'(la_s), 32'({1'h1, r.addr[23:17]}));
		chk_v(32'(len >= r.lo && len <= r.hi), 32'h1);
	endtask

	// main sequence: table, then stall, abort, side inputs, refresh, second reset
	initial begin
		{cv, cio, cw, abort, iocs16_n, memcs16_n, zws_n, chk_n} = 8'h0F;
		{caddr, cwd, sd_in, irq, drq, rdy} = 81'h1;
		n_mismatch = 0;
		num_checks = 0;
		do_reset(1'h0);
		per_chk(3);
		irq = 16'h0018;
		drq = 8'h12;
		foreach (rows[i]) begin
			run(rows[i]);
			$display("row %0d done", i);
		end
		fork
			run('{1'h1, 1'h0, 1'h0, 1'h0, 32'h0000_0301, 8'h00, 16'h5A3C, 8'h3C, 13, 999});
			begin
				// stall only once our strobe is out, so a refresh cannot soak up the wait
				for (int i = 0; i < 400 && !(ior_n === 1'h0 && aen === 1'h0); i++)
					@(negedge clk);
				rdy = 1'h0;
				repeat (60) @(negedge clk);
				rdy = 1'h1;
			end
		join
		$display("stall done");
		rdy = 1'h0;
		issue(rows[0]);
		repeat (30) @(negedge clk);
		abort = 1'h1;
		@(negedge clk);
		abort = 1'h0;
		rdy = 1'h1;
		run(rows[1]);
		$display("abort done");
		chk_v(32'(dmar), 32'h02);
		chk_v(32'(irql), 32'h18);
		chk_n = 1'h0;
		repeat (3) @(negedge clk);
		chk_v(32'(chan), 32'h1);
		for (int i = 0; i < 400 && ref_n !== 1'h0; i++) @(negedge clk);
		chk_v(32'({ref_n, ref_oe, aen, bale, la_oe, sa_oe, cmd_oe}), 32'h3B);
		$display("side inputs done");
		do_reset(1'h1);
		per_chk(4);
		run('{1'h1, 1'h1, 1'h0, 1'h0, 32'h0000_0300, 8'hA5, 16'h0000, 8'h00, 16, 16});
		$display("divide by four done");
		final_report();
	end
endmodule
